// ==== design/user_flash_serial_access.v ====
// Purpose: user flash block with serial address/data port and APB registers
// Assumes: pclk 40 MHz, presetn asynchronous active low, pins asynchronous
// Notes: read words pass through a 16-word FIFO before the data shifter
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/100ps
`include "user_flash_regs.vh"

module user_flash_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire pclk,
	input wire presetn,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire out_valid,
	input wire out_ready,
	output wire [AW:0] level
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0] cnt_q;
	wire push;
	wire pop;

	assign in_ready = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign out_data = mem[rd_q];
	assign level = cnt_q;
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always @(posedge pclk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			if (push & ~pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop & ~push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////

module user_flash_serial_access #(
	parameter PROG_CYCLES = `UF_PROG_CYCLES,
	parameter ERASE_CYCLES = `UF_ERASE_CYCLES,
	parameter OSC_DIV = `UF_OSC_DIV,
	parameter FIFO_DEPTH = 16
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire program_req,
	input wire erase_req,
	input wire addr_shift_ctl,
	input wire addr_shift_clock,
	input wire addr_serial_in,
	input wire data_shift_ctl,
	input wire data_shift_clock,
	input wire data_serial_in,
	input wire [3:0] global_clock_lines,
	input wire tap_clock,
	input wire tap_mode,
	input wire tap_data_in,
	output reg tap_data_out,
	output reg busy,
	output reg data_serial_out,
	output reg osc_div4
);
	localparam NSYNC = 15;
	localparam [15:0] PROG_N = PROG_CYCLES[15:0];
	localparam [15:0] ERASE_N = ERASE_CYCLES[15:0];
	localparam [7:0] OSC_N = OSC_DIV[7:0];

	reg [15:0] mem [0:`UF_WORDS-1];
	reg [NSYNC-1:0] s1_q;
	reg [NSYNC-1:0] s2_q;
	reg [2:0] ctrl_q;
	reg [11:0] src_q;
	reg [8:0] addr_q;
	reg [15:0] data_q;
	reg [1:0] st_q;
	reg [15:0] cnt_q;
	reg [7:0] wipe_q;
	reg sector_q;
	reg aclk_q;
	reg dclk_q;
	reg [7:0] osc_q;
	reg [1:0] div_q;
	reg ctrl_prog_q;
	reg ctrl_erase_q;
	reg [3:0] pick;
	reg aclk_rise;
	reg dclk_rise;
	wire [NSYNC-1:0] pins;
	wire [3:0] gcl;
	wire tap;
	wire ashift;
	wire ain;
	wire dshift;
	wire din;
	wire prog_in;
	wire erase_in;
	wire aclk_in;
	wire dclk_in;
	wire fifo_in_ready;
	wire fifo_valid;
	wire [15:0] fifo_data;
	wire fifo_pop;
	wire [4:0] fifo_level;
	wire stream_push;
	wire acc_wr;
	wire [31:0] status;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: every pin passes two flip-flops
	assign pins = {tap_data_in, tap_mode, tap_clock, global_clock_lines,
		data_serial_in, data_shift_clock, data_shift_ctl, addr_serial_in,
		addr_shift_clock, addr_shift_ctl, erase_req, program_req};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi = gi + 1) begin : sync
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1_q[gi] <= 1'b0;
					s2_q[gi] <= 1'b0;
				end else begin
					s1_q[gi] <= pins[gi];
					s2_q[gi] <= s1_q[gi];
				end
			end
		end
	endgenerate

	assign gcl = s2_q[11:8];

	////////////////////////////////////////////////////////////////////////////
	// source selection per input: routing or a global line
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : srcmux
			always @* begin
				pick[gi] = s2_q[gi == 0 ? 0 : gi == 1 ? 1 : gi == 2 ? 3 : 6];
				if (src_q[gi*3+2]) begin
					pick[gi] = gcl[src_q[gi*3+1 -: 2]];
				end
			end
		end
	endgenerate

	// alternate test access port takes over the serial interface
	assign tap = ctrl_q[`UF_CTRL_TAP_BIT];
	assign prog_in = tap ? ctrl_prog_q : pick[0];
	assign erase_in = tap ? ctrl_erase_q : pick[1];
	assign aclk_in = tap ? (s2_q[12] & ~s2_q[13]) : pick[2];
	assign dclk_in = tap ? (s2_q[12] & s2_q[13]) : pick[3];
	assign ashift = tap ? 1'b1 : s2_q[2];
	assign ain = tap ? s2_q[14] : s2_q[4];
	assign dshift = tap ? 1'b1 : s2_q[5];
	assign din = tap ? s2_q[14] : s2_q[7];

	always @* begin
		aclk_rise = aclk_in & ~aclk_q;
		dclk_rise = dclk_in & ~dclk_q;
	end

	////////////////////////////////////////////////////////////////////////////
	// address register, data shifter and read path
	assign stream_push = aclk_rise & ~ashift & (st_q == `UF_ST_IDLE);
	assign fifo_pop = dclk_rise & ~dshift;

	user_flash_fifo #(
		.WIDTH(16),
		.DEPTH(FIFO_DEPTH),
		.AW(4)
	) rd_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.in_data(mem[addr_q]),
		.in_valid(stream_push),
		.in_ready(fifo_in_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.level(fifo_level)
	);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aclk_q <= 1'b0;
			dclk_q <= 1'b0;
			addr_q <= 9'h000;
			data_q <= 16'h0000;
		end else begin
			aclk_q <= aclk_in;
			dclk_q <= dclk_in;
			if (aclk_rise & ashift) begin
				addr_q <= {addr_q[7:0], ain};
			end else if (stream_push & fifo_in_ready) begin
				// a full fifo holds the address until words drain
				addr_q <= addr_q + 9'h001;
			end
			if (dclk_rise & dshift) begin
				data_q <= {data_q[14:0], din};
			end else if (fifo_pop & fifo_valid) begin
				data_q <= fifo_data;
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_serial_out <= 1'b0;
			tap_data_out <= 1'b0;
		end else begin
			data_serial_out <= data_q[15];
			tap_data_out <= data_q[15];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// program / erase engine
	always @(posedge pclk) begin
		if (st_q == `UF_ST_PROG && cnt_q == 16'h0000) begin
			mem[addr_q] <= data_q;
		end else if (st_q == `UF_ST_ERASE && cnt_q == 16'h0000) begin
			mem[{sector_q, wipe_q}] <= `UF_ERASED;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= `UF_ST_IDLE;
			cnt_q <= 16'h0000;
			wipe_q <= 8'h00;
			sector_q <= 1'b0;
			busy <= 1'b0;
		end else begin
			case (st_q)
				`UF_ST_IDLE: begin
					if (prog_in) begin
						st_q <= `UF_ST_PROG;
						cnt_q <= PROG_N;
						busy <= 1'b1;
					end else if (erase_in) begin
						st_q <= `UF_ST_ERASE;
						cnt_q <= ERASE_N;
						wipe_q <= 8'h00;
						sector_q <= addr_q[8];
						busy <= 1'b1;
					end
				end
				`UF_ST_PROG: begin
					// programming writes data_q over the whole word, setting bits as well as clearing them
					if (cnt_q == 16'h0000) begin
						st_q <= `UF_ST_DONE;
						busy <= 1'b0;
					end else begin
						cnt_q <= cnt_q - 16'h0001;
					end
				end
				`UF_ST_ERASE: begin
					if (cnt_q != 16'h0000) begin
						cnt_q <= cnt_q - 16'h0001;
					end else if (wipe_q == 8'hff) begin
						st_q <= `UF_ST_DONE;
						busy <= 1'b0;
					end else begin
						wipe_q <= wipe_q + 8'h01;
					end
				end
				`UF_ST_DONE: begin
					// wait for the request to drop so one request runs once
					if (!prog_in && !erase_in) begin
						st_q <= `UF_ST_IDLE;
					end
				end
				default: begin
					st_q <= `UF_ST_IDLE;
					busy <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// internal oscillator and its divide-by-four output
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_q <= 8'h00;
			div_q <= 2'h0;
			osc_div4 <= 1'b0;
		end else begin
			if (osc_q == OSC_N - 8'h01) begin
				osc_q <= 8'h00;
				div_q <= div_q + 2'h1;
			end else begin
				osc_q <= osc_q + 8'h01;
			end
			osc_div4 <= div_q[1];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// APB slave: answer registered in the setup cycle, write on access
	assign acc_wr = psel & penable & pready & pwrite;
	assign status = {15'h0000, addr_q, fifo_level, fifo_valid, fifo_in_ready, busy};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			ctrl_q <= `UF_CTRL_RST;
			src_q <= `UF_SRC_RST;
			ctrl_prog_q <= 1'b0;
			ctrl_erase_q <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			// error flag stands only beside pready, in the access cycle
			pslverr <= 1'b0;
			if (psel & ~penable) begin
				case (paddr)
					`UF_CTRL_OFS: prdata <= {29'h0, ctrl_q};
					`UF_SRC_OFS: prdata <= {20'h00000, src_q};
					`UF_STATUS_OFS: prdata <= status;
					`UF_DATA_OFS: prdata <= {16'h0000, data_q};
					`UF_ADDR_OFS: prdata <= {23'h000000, addr_q};
					default: begin
						prdata <= 32'h00000000;
						pslverr <= 1'b1;
					end
				endcase
			end
			if (acc_wr && paddr == `UF_CTRL_OFS) begin
				ctrl_q <= pwdata[2:0];
				ctrl_prog_q <= pwdata[`UF_CTRL_PROG_BIT];
				ctrl_erase_q <= pwdata[`UF_CTRL_ERASE_BIT];
			end
			if (acc_wr && paddr == `UF_SRC_OFS) begin
				src_q <= pwdata[11:0];
			end
		end
	end
endmodule

// ==== design/user_flash_regs.vh ====
// Purpose: constants for the user flash serial access block
// Assumes: APB byte addresses, 32-bit data
// Notes: timing counts are in pclk cycles
`ifndef USER_FLASH_REGS_VH
`define USER_FLASH_REGS_VH

`define UF_ADDR_BITS 9
`define UF_DATA_BITS 16
`define UF_WORDS 512
`define UF_SECTOR_WORDS 256
`define UF_ERASED 16'hffff

// register byte offsets
`define UF_CTRL_OFS 8'h00
`define UF_SRC_OFS 8'h04
`define UF_STATUS_OFS 8'h08
`define UF_DATA_OFS 8'h0c
`define UF_ADDR_OFS 8'h10

// control fields
`define UF_CTRL_TAP_BIT 0
`define UF_CTRL_PROG_BIT 1
`define UF_CTRL_ERASE_BIT 2
`define UF_CTRL_RST 3'h0

// input source select: 0 = routing, 4..7 = global line 0..3
`define UF_SRC_RST 12'h000
`define UF_SRC_W 3

// timing in pclk cycles
`define UF_PROG_CYCLES 64
`define UF_ERASE_CYCLES 256
`define UF_OSC_DIV 10

// busy engine states
`define UF_ST_IDLE 2'h0
`define UF_ST_PROG 2'h1
`define UF_ST_ERASE 2'h2
`define UF_ST_DONE 2'h3

`endif

// ==== test/user_flash_serial_access_sva.sv ====
// Purpose: port checks for the flash access block
// Assumes: bound to the top module
// Notes: busy length counted in helper logic
`timescale 1ns/100ps
module user_flash_serial_access_sva #(
	parameter PROG_CYCLES = 64,
	parameter ERASE_CYCLES = 256
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire program_req,
	input wire erase_req,
	input wire [3:0] global_clock_lines,
	input wire busy,
	input wire osc_div4
);
	reg [9:0] len_q;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			len_q <= 10'h000;
		else
			len_q <= busy ? len_q + 10'h001 : 10'h000;
	end
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_setup; psel && !penable; endsequence
	sequence s_answer; pready ##1 !pready; endsequence
	property p_answer; s_setup |=> s_answer; endproperty
	a_answer: assert property (p_answer) else $error("setup not answered once");
	property p_stray; pready |-> $past(psel) && !$past(penable); endproperty
	a_stray: assert property (p_stray) else $error("ready without setup");
	property p_err; pslverr |-> pready && psel && penable; endproperty
	a_err: assert property (p_err) else $error("error outside access");
	property p_err_data; pslverr && !pwrite |-> prdata == 32'h00000000; endproperty
	a_err_data: assert property (p_err_data) else $error("refused read data");
	property p_cause; $rose(busy) |-> program_req || erase_req || (|global_clock_lines); endproperty
	a_cause: assert property (p_cause) else $error("busy without request");
	property p_len;
		$fell(busy) |-> len_q == PROG_CYCLES + 1 || len_q == ERASE_CYCLES + 256;
	endproperty
	a_len: assert property (p_len) else $error("busy length");
	property p_end; $rose(busy) |-> ##[1:600] !busy; endproperty
	a_end: assert property (p_end) else $error("busy stuck");
	property p_osc; $rose(osc_div4) |-> ##[1:64] $fell(osc_div4); endproperty
	a_osc: assert property (p_osc) else $error("divided clock stuck");
endmodule

// ==== test/user_flash_user_logic.sv ====
// Purpose: user logic model on the flash serial pins
// Assumes: serial clocks stay low outside frames
// Notes: the testbench calls its tasks
`timescale 1ns/100ps
module user_flash_user_logic (
	input wire pclk,
	input wire busy,
	input wire data_serial_out,
	output wire program_req,
	output wire erase_req,
	output wire [3:0] global_clock_lines,
	output reg addr_shift_ctl = 1'b0,
	output reg addr_shift_clock = 1'b0,
	output reg addr_serial_in = 1'b0,
	output reg data_shift_ctl = 1'b0,
	output reg data_shift_clock = 1'b0,
	output reg data_serial_in = 1'b0
);
	reg [5:0] req_q = 6'h00;
	assign {global_clock_lines, erase_req, program_req} = req_q;
	// the idle serial line toggles so a stale bit never looks valid
	task pulse(input sel, input ctl, input d);
		begin
			{data_shift_ctl, data_serial_in} <= sel ? {ctl, d} : {data_shift_ctl, ~data_serial_in};
			{addr_shift_ctl, addr_serial_in} <= sel ? {addr_shift_ctl, ~addr_serial_in} : {ctl, d};
			@(posedge pclk);
			{data_shift_clock, addr_shift_clock} <= sel ? 2'b10 : 2'b01;
			repeat (4) @(posedge pclk);
			{data_shift_clock, addr_shift_clock} <= 2'b00;
			repeat (4) @(posedge pclk);
		end
	endtask
	task bits(input sel, input [15:0] v, input integer c, output [15:0] q);
		integer i;
		begin
			for (i = c - 1; i >= 0; i = i - 1) begin
				q = {q[14:0], data_serial_out};
				pulse(sel, 1'b1, v[i]);
			end
		end
	endtask
	task req(input integer k, output integer n);
		integer w;
		begin
			n = 0;
			req_q[k] <= 1'b1;
			for (w = 0; w < 20 && busy !== 1'b1; w = w + 1)
				@(posedge pclk);
			while (busy === 1'b1) begin
				@(posedge pclk);
				n = n + 1;
			end
			req_q[k] <= 1'b0;
			repeat (4) @(posedge pclk);
		end
	endtask
endmodule

// ==== test/user_flash_serial_access_tb.sv ====
// Purpose: self-checking bench for the flash access block
// Assumes: short timing parameters, 40 MHz pclk
// Notes: serial pins come from the user logic model
`timescale 1ns/100ps
`include "user_flash_regs.vh"
module user_flash_serial_access_tb;
	reg pclk = 1'b0;
	reg presetn = 1'b0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h00000000;
	reg tap_clock = 1'b0;
	reg tap_mode = 1'b0;
	reg tap_data_in = 1'b0;
	wire tap_data_out;
	wire [31:0] prdata;
	wire [3:0] global_clock_lines;
	wire pready, pslverr, busy, data_serial_out, osc_div4, program_req, erase_req;
	wire addr_shift_ctl, addr_shift_clock, addr_serial_in;
	wire data_shift_ctl, data_shift_clock, data_serial_in;
	integer err_count = 0;
	integer num_checks = 0;
	integer n;
	reg [31:0] v;
	reg [15:0] d;
	reg e;
	initial begin
		forever #12.5 pclk = ~pclk;
	end
	user_flash_serial_access #(.PROG_CYCLES(4), .ERASE_CYCLES(4), .OSC_DIV(2), .FIFO_DEPTH(16))
		user_flash_serial_access_inst (.*);
	user_flash_user_logic ul (.*);
	task chk(input [31:0] got, input [31:0] exp);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task apb(input w, input [7:0] a, input [31:0] wd);
		begin
			@(posedge pclk);
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= a;
			pwdata <= wd;
			@(posedge pclk);
			penable <= 1'b1;
			do
				@(posedge pclk);
			while (pready !== 1'b1);
			v = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	// test port shifter: mode low moves address bits, mode high moves data bits
	task tap_bits(input m, input [15:0] w, input integer c, output [15:0] q);
		integer i;
		begin
			for (i = c - 1; i >= 0; i = i - 1) begin
				q = {q[14:0], tap_data_out};
				tap_mode <= m;
				tap_data_in <= w[i];
				@(posedge pclk);
				tap_clock <= 1'b1;
				repeat (4) @(posedge pclk);
				tap_clock <= 1'b0;
				repeat (4) @(posedge pclk);
			end
		end
	endtask
	task rd(input [7:0] a, input [31:0] x);
		begin
			apb(1'b0, a, 32'h00000000);
			chk(v, x);
		end
	endtask
	task summarize;
		begin
			if (err_count == 0 && num_checks > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task t_regs;
		begin
			rd(`UF_CTRL_OFS, 32'h00000000);
			rd(`UF_SRC_OFS, 32'h00000000);
			apb(1'b0, 8'h14, 32'h00000000);
			chk({31'h0, e}, 32'h00000001);
			chk(v, 32'h00000000);
			apb(1'b1, `UF_SRC_OFS, 32'h00000038);
			rd(`UF_SRC_OFS, 32'h00000038);
		end
	endtask
	task t_prog;
		begin
			ul.bits(1'b0, 16'h0000, 9, d);
			ul.req(5, n);
			chk(n, 32'h00000104);
			apb(1'b1, `UF_SRC_OFS, 32'h00000000);
			ul.bits(1'b0, 16'h0300, 10, d);
			rd(`UF_ADDR_OFS, 32'h00000100);
			ul.req(1, n);
			chk(n, 32'h00000104);
			ul.bits(1'b1, 16'ha5c3, 16, d);
			ul.req(0, n);
			chk(n, 32'h00000005);
			ul.bits(1'b0, 16'h00ff, 9, d);
			ul.pulse(1'b1, 1'b1, 1'b1);
			ul.bits(1'b1, 16'h1234, 16, d);
			rd(`UF_DATA_OFS, 32'h00001234);
			ul.req(0, n);
			chk(n, 32'h00000005);
		end
	endtask
	task t_stream;
		integer i;
		begin
			ul.bits(1'b0, 16'h00ff, 9, d);
			for (i = 0; i < 17; i = i + 1)
				ul.pulse(1'b0, 1'b0, 1'b0);
			rd(`UF_STATUS_OFS, 32'h00010f84);
			for (i = 0; i < 16; i = i + 1) begin
				ul.pulse(1'b1, 1'b0, 1'b0);
				ul.bits(1'b1, 16'h0000, 16, d);
				chk(d, i == 0 ? 32'h1234 : i == 1 ? 32'ha5c3 : 32'hffff);
			end
			rd(`UF_STATUS_OFS, 32'h00010f02);
			ul.bits(1'b0, 16'h0100, 9, d);
			ul.pulse(1'b0, 1'b0, 1'b0);
			ul.pulse(1'b1, 1'b0, 1'b0);
			ul.bits(1'b1, 16'h0000, 16, d);
			chk(d, 32'h0000a5c3);
		end
	endtask
	task t_tap;
		begin
			apb(1'b1, `UF_CTRL_OFS, 32'h00000001);
			rd(`UF_CTRL_OFS, 32'h00000001);
			tap_bits(1'b0, 16'h00a5, 9, d);
			rd(`UF_ADDR_OFS, 32'h000000a5);
			tap_bits(1'b1, 16'h3c69, 16, d);
			rd(`UF_DATA_OFS, 32'h00003c69);
			tap_bits(1'b1, 16'h0000, 16, d);
			chk(d, 32'h00003c69);
			apb(1'b1, `UF_CTRL_OFS, 32'h00000000);
			rd(`UF_CTRL_OFS, 32'h00000000);
		end
	endtask
	// divided clock with a two-cycle oscillator tick stays high four cycles
	task t_osc;
		begin
			n = 0;
			while (osc_div4 !== 1'b0)
				@(posedge pclk);
			while (osc_div4 !== 1'b1)
				@(posedge pclk);
			while (osc_div4 === 1'b1) begin
				n = n + 1;
				@(posedge pclk);
			end
			chk(n, 32'h00000004);
		end
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_prog;
		t_stream;
		t_tap;
		t_osc;
		summarize;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		err_count = err_count + 1;
		summarize;
	end
endmodule
bind user_flash_serial_access user_flash_serial_access_sva #(.PROG_CYCLES(PROG_CYCLES),
	.ERASE_CYCLES(ERASE_CYCLES)) chk_inst (.*);
